// ==== core/bitplane_fetch_address_gen.sv ====
// bit-plane fetch address generator with an AHB-Lite register slave
// assumes memory answers mem_req with a one-cycle mem_ack on sys_clk
//
// Summary of operation
// R01: fetch positions count in four-pixel steps
// R02: software keeps fetch start on 16-pixel grid
// R03: display starts 8.5 or 4.5 clocks later
// R04: normal fetch start 0038 or 003C
// R05: start equals stop minus slot span
// R06: normal fetch stop 00D0 or 00D4
// R07: pointer advances one word per fetch
// R08: line end adds skip count to pointer
// R09: plane pointers always hold even addresses
// R10: odd and even planes use separate skips
// R11: high resolution fetches 80 bytes per line
// R12: interlace uses skip 40, even field offset
// R13: fetch only while plane DMA enabled
// R14: software reloads pointers before every frame
// R15: control bit 9 enables composite colour burst
// R16: control bits 12-14 give plane count
// R17: control bit 15 selects high resolution
// R18: control bit 2 selects interlaced scanning
// R19: window registers hold vertical high, horizontal low
// R20: software limits height to 200/400 lines
// R21: software limits width to 320/640 pixels
// R22: vertical stop top bit is complemented
// R23: window positions use low-res non-interlaced units
// R24: fetch one word per enabled plane only
// R25: no fetch outside fetch window or disabled
`include "bitplane_fetch_defines.svh"
module bitplane_fetch_address_gen (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic mem_req,
  output logic [`PTR_W-1:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic [15:0] plane_word,
  output logic plane_word_valid,
  output logic [2:0] plane_word_index,
  output logic display_start,
  output logic in_display_window,
  output logic colour_burst_en,
  output logic hires_mode,
  output logic interlace_mode,
  output logic long_field,
  output logic fetch_line_end
);
  bitplane_fetch_pkg::fetch_core_t state;
  bitplane_fetch_pkg::fetch_core_t next_state;
  ptr_bus_if pb ();

  plane_pointer_bank u_bank (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .pb(pb)
  );

  function automatic logic [2:0] planes_of(input logic [15:0] c);
    logic [2:0] n;
    n = c[`CTL_COUNT_HI:`CTL_COUNT_LO];
    planes_of = (n > `MAX_PLANES_3) ? `MAX_PLANES_3 : n;
  endfunction

  // plane number of a pointer register, bit 3 flags a miss
  function automatic logic [3:0] ptr_plane_of(input logic [11:0] idx);
    logic [11:0] rel;
    rel = idx - `IDX_PTR_BASE;
    if (idx < `IDX_PTR_BASE || idx > `IDX_PTR_LAST || rel[0]) begin
      ptr_plane_of = 4'h8;
    end else begin
      ptr_plane_of = {1'b0, rel[4:2]};
    end
  endfunction

  logic half_tick;
  logic pos_tick;
  logic dma_on;
  logic [2:0] planes;
  logic [7:0] last_slot;
  logic [7:0] rel_pos;
  logic aligned;
  logic in_fetch;
  logic [8:0] vertical_end_position;
  logic v_in;
  logic [9:0] hpix;
  logic take;
  logic wr_ph;
  logic [3:0] wr_ptr_plane;
  logic [3:0] rd_ptr_plane;
  logic [11:0] rd_idx;

  always_comb begin
    half_tick = state.div_cnt == `HALF_CLK_LAST;
    pos_tick = half_tick && state.sub_cnt == `PIX_PER_POS_LAST;
    dma_on = state.dma_ctl[`DMA_PLANE_EN_BIT]; // R13
    planes = planes_of(state.ctl_main); // R16
    // hires runs one slot past stop: one word more per plane per line
    last_slot = state.fetch_stop[7:0]
      + (state.hires ? `HIRES_EXTRA : 8'h00); // R05 R11
    rel_pos = state.hpos - state.fetch_start[7:0]; // R01
    aligned = state.hires ? (rel_pos & `SLOT_MASK_HIRES) == 8'h00
      : (rel_pos & `SLOT_MASK_LORES) == 8'h00;
    vertical_end_position = {~state.win_stop[`WIN_V_HI],
      state.win_stop[`WIN_V_HI:`WIN_V_LO]}; // R22 R19
    v_in = state.vpos >= {1'b0, state.win_start[`WIN_V_HI:`WIN_V_LO]}
      && state.vpos < vertical_end_position; // R23
    in_fetch = dma_on && v_in && planes != 3'h0
      && state.hpos >= state.fetch_start[7:0]
      && state.hpos <= last_slot; // R25
    hpix = {state.hpos, state.sub_cnt};
    take = hsel && htrans[1] && hready;
    wr_ph = state.addr_ph && state.addr_wr;
    wr_ptr_plane = ptr_plane_of(state.addr_idx);
    rd_idx = haddr[13:2];
    rd_ptr_plane = ptr_plane_of(rd_idx);
  end

  always_comb begin
    pb.wr_hi = wr_ph && !wr_ptr_plane[3] && !state.addr_idx[1];
    pb.wr_lo = wr_ph && !wr_ptr_plane[3] && state.addr_idx[1];
    pb.wr_plane = wr_ptr_plane[2:0];
    pb.wr_data = hwdata[15:0];
    pb.step = state.fstate == bitplane_fetch_pkg::FETCH_WAIT && mem_ack;
    pb.step_plane = state.plane;
    pb.eol_add = state.eol_pending && !state.slot_pending
      && state.fstate == bitplane_fetch_pkg::FETCH_IDLE;
    pb.eol_planes = planes;
    pb.odd_skip = state.odd_skip;
    pb.even_skip = state.even_skip;
    // plane of the next request: 0 at a slot, the following one in a burst
    pb.rd_plane = state.fstate == bitplane_fetch_pkg::FETCH_WAIT
      ? state.plane + 3'h1 : 3'h0;
  end

  always_comb begin
    next_state = state;
    next_state.display_start = 1'b0;
    next_state.plane_word_valid = 1'b0;
    next_state.line_end = 1'b0;
    next_state.hreadyout = 1'b1;
    // register slave: address phase then write in data phase
    next_state.addr_ph = take;
    if (take) begin
      next_state.addr_wr = hwrite;
      next_state.addr_idx = rd_idx;
      next_state.hrdata = 32'h0000_0000;
      if (!hwrite) begin
        unique case (rd_idx)
          `IDX_BEAM_STATUS: next_state.hrdata = {6'h00,
            state.fstate != bitplane_fetch_pkg::FETCH_IDLE,
            state.long_field, 7'h00, state.vpos, state.hpos};
          `IDX_WIN_START: next_state.hrdata[15:0] = state.win_start;
          `IDX_WIN_STOP: next_state.hrdata[15:0] = state.win_stop;
          `IDX_FETCH_START: next_state.hrdata[15:0] = state.fetch_start;
          `IDX_FETCH_STOP: next_state.hrdata[15:0] = state.fetch_stop;
          `IDX_DMA_CTL: next_state.hrdata[15:0] = state.dma_ctl;
          `IDX_CTL_MAIN: next_state.hrdata[15:0] = state.ctl_main;
          `IDX_SCROLL: next_state.hrdata[15:0] = state.scroll;
          `IDX_ODD_SKIP: next_state.hrdata[15:0] = state.odd_skip;
          `IDX_EVEN_SKIP: next_state.hrdata[15:0] = state.even_skip;
          default: next_state.hrdata = 32'h0000_0000;
        endcase
        // pointers are load-only; a read returns zero
        if (!rd_ptr_plane[3]) begin
          next_state.hrdata = 32'h0000_0000;
        end
      end
    end
    if (wr_ph) begin
      unique case (state.addr_idx)
        `IDX_WIN_START: next_state.win_start = hwdata[15:0];
        `IDX_WIN_STOP: next_state.win_stop = hwdata[15:0];
        `IDX_FETCH_START: next_state.fetch_start = hwdata[15:0];
        `IDX_FETCH_STOP: next_state.fetch_stop = hwdata[15:0];
        `IDX_DMA_CTL: next_state.dma_ctl = hwdata[15:0];
        `IDX_CTL_MAIN: next_state.ctl_main = hwdata[15:0];
        `IDX_SCROLL: next_state.scroll = hwdata[15:0];
        `IDX_ODD_SKIP: next_state.odd_skip = hwdata[15:0];
        `IDX_EVEN_SKIP: next_state.even_skip = hwdata[15:0];
        default: next_state.addr_wr = 1'b0;
      endcase
    end
    next_state.burst_en = state.ctl_main[`CTL_BURST_BIT]; // R15
    next_state.hires = state.ctl_main[`CTL_HIRES_BIT]; // R17
    next_state.alternate_field_scan_select = state.ctl_main[`CTL_ALTERNATE_FIELD_SCAN_SELECT_BIT]; // R18
    // beam counters, one position is four low-res pixels
    next_state.div_cnt = half_tick ? 3'h0 : state.div_cnt + 3'h1;
    if (half_tick) begin
      next_state.sub_cnt = state.sub_cnt + 2'h1;
      if (state.lat_cnt != 5'h00) begin
        next_state.lat_cnt = state.lat_cnt - 5'h01;
        next_state.display_start = state.lat_cnt == 5'h01; // R03
      end
    end
    if (pos_tick) begin
      if (in_fetch && aligned) begin
        next_state.slot_pending = 1'b1;
        if (!state.line_fetched) begin
          next_state.lat_cnt = state.hires ? `LAT_HIRES : `LAT_LORES; // R03
        end
        next_state.line_fetched = 1'b1;
      end
      if (state.hpos == last_slot && state.line_fetched) begin
        next_state.eol_pending = 1'b1; // R08
      end
      if (state.hpos == `HPOS_LAST) begin
        next_state.hpos = 8'h00;
        next_state.line_fetched = 1'b0;
        if (state.vpos == `VPOS_LAST) begin
          next_state.vpos = 9'h000;
          next_state.long_field = state.alternate_field_scan_select ? ~state.long_field : 1'b1;
        end else begin
          next_state.vpos = state.vpos + 9'h001;
        end
      end else begin
        next_state.hpos = state.hpos + 8'h01;
      end
    end
    next_state.in_window = v_in
      && hpix >= {2'h0, state.win_start[`WIN_H_HI:`WIN_H_LO]}
      && hpix < {`HORIZONTAL_END_POSITION_TOP, state.win_stop[`WIN_H_HI:`WIN_H_LO]}; // R23
    if (pb.eol_add) begin
      next_state.eol_pending = 1'b0;
      next_state.line_end = 1'b1;
    end
    unique case (state.fstate)
      bitplane_fetch_pkg::FETCH_IDLE: begin
        if (state.slot_pending) begin
          next_state.slot_pending = 1'b0;
          if (dma_on && planes != 3'h0) begin // R13 R25
            next_state.plane = 3'h0;
            next_state.mem_req = 1'b1;
            next_state.mem_addr = pb.rd_ptr;
            next_state.fstate = bitplane_fetch_pkg::FETCH_WAIT;
          end
        end
      end
      bitplane_fetch_pkg::FETCH_WAIT: begin
        if (mem_ack) begin
          next_state.mem_req = 1'b0;
          next_state.plane_word = mem_rdata;
          next_state.plane_word_valid = 1'b1;
          next_state.plane_word_index = state.plane;
          next_state.plane = state.plane + 3'h1;
          if (state.plane + 3'h1 < planes && dma_on) begin // R24
            next_state.mem_req = 1'b1;
            next_state.mem_addr = pb.rd_ptr;
          end else begin
            next_state.fstate = bitplane_fetch_pkg::FETCH_IDLE;
          end
        end
      end
    endcase
  end

  // address latched with the request, so it stands until its ack
  always_comb begin
    mem_addr = state.mem_addr;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.hreadyout <= 1'b1;
      state.long_field <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    hreadyout = state.hreadyout;
    hrdata = state.hrdata;
    hresp = 1'b0;
    mem_req = state.mem_req;
    plane_word = state.plane_word;
    plane_word_valid = state.plane_word_valid;
    plane_word_index = state.plane_word_index;
    display_start = state.display_start;
    in_display_window = state.in_window;
    colour_burst_en = state.burst_en;
    hires_mode = state.hires;
    interlace_mode = state.alternate_field_scan_select;
    long_field = state.long_field;
    fetch_line_end = state.line_end;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_no_fetch_disabled;
    $rose(mem_req) |-> $past(dma_on);
  endproperty
  a_no_fetch_disabled: assert property (p_no_fetch_disabled) // R13 R25
    else $error("fetch started with plane DMA disabled");

  property p_plane_limit;
    mem_req |-> state.plane < planes_of(state.ctl_main)
      || !$stable(state.ctl_main);
  endproperty
  a_plane_limit: assert property (p_plane_limit) // R24 R16
    else $error("fetch issued for a plane beyond the count");

  property p_slot_in_window;
    pos_tick && in_fetch && aligned |=> state.slot_pending
      && state.hpos == $past(state.hpos) + 8'h01 || state.hpos == 8'h00;
  endproperty
  a_slot_in_window: assert property (p_slot_in_window) // R01 R05
    else $error("fetch slot not raised inside fetch window");

  sequence s_first_slot;
    pos_tick && in_fetch && aligned && !state.line_fetched;
  endsequence
  sequence s_latency_run;
    (state.lat_cnt != 5'h00) [*8] ##[1:120] display_start;
  endsequence
  property p_latency;
    s_first_slot |=> s_latency_run;
  endproperty
  a_latency: assert property (p_latency) // R03
    else $error("display start not after fetch latency");

  property p_modes;
    ##1 hires_mode == $past(state.ctl_main[`CTL_HIRES_BIT])
      && interlace_mode == $past(state.ctl_main[`CTL_ALTERNATE_FIELD_SCAN_SELECT_BIT]);
  endproperty
  a_modes: assert property (p_modes) // R17 R18
    else $error("resolution or interlace output wrong");

  property p_burst;
    ##1 colour_burst_en == $past(state.ctl_main[`CTL_BURST_BIT]);
  endproperty
  a_burst: assert property (p_burst) // R15
    else $error("colour burst enable does not follow control");

  property p_vertical_end_position;
    vertical_end_position[8] == ~state.win_stop[`WIN_V_HI]
      && vertical_end_position[7:0] == state.win_stop[`WIN_V_HI:`WIN_V_LO];
  endproperty
  a_vertical_end_position: assert property (p_vertical_end_position) // R22 R19
    else $error("vertical stop top bit not complemented");

  property p_step_on_ack;
    mem_req && mem_ack |=> plane_word_valid
      && plane_word_index == $past(state.plane);
  endproperty
  a_step_on_ack: assert property (p_step_on_ack) // R07
    else $error("fetched word not delivered after ack");

  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay)
    else $error("slave answer not ready and okay");
endmodule

// ==== core/bitplane_fetch_defines.svh ====
// constants for the bit-plane fetch address generator
// assumes a 40 MHz sys_clk and word-wide display memory reads
`ifndef BITPLANE_FETCH_DEFINES_SVH
`define BITPLANE_FETCH_DEFINES_SVH

`define SYS_CLK_MHZ 40
`define HALF_CLK_NS 140
`define HALF_CLK_CYC ((`HALF_CLK_NS * `SYS_CLK_MHZ) / 1000)
`define HALF_CLK_LAST 3'(`HALF_CLK_CYC - 1)
`define PIX_PER_POS_LAST 2'h3
`define HPOS_LAST 8'hE3
`define VPOS_LAST 9'h106
`define LAT_LORES 5'h11
`define LAT_HIRES 5'h09
`define SLOT_MASK_LORES 8'h07
`define SLOT_MASK_HIRES 8'h03
`define HIRES_EXTRA 8'h04
`define PTR_W 19
`define WORD_BYTES 19'h0_0002
`define MAX_PLANES 6
`define MAX_PLANES_3 3'h6

`define IDX_BEAM_STATUS 12'h006
`define IDX_WIN_START 12'h08E
`define IDX_WIN_STOP 12'h090
`define IDX_FETCH_START 12'h092
`define IDX_FETCH_STOP 12'h094
`define IDX_DMA_CTL 12'h096
`define IDX_PTR_BASE 12'h0E0
`define IDX_PTR_LAST 12'h0F6
`define IDX_CTL_MAIN 12'h100
`define IDX_SCROLL 12'h102
`define IDX_ODD_SKIP 12'h108
`define IDX_EVEN_SKIP 12'h10A

`define CTL_HIRES_BIT 15
`define CTL_COUNT_HI 14
`define CTL_COUNT_LO 12
`define CTL_BURST_BIT 9
`define CTL_ALTERNATE_FIELD_SCAN_SELECT_BIT 2
`define DMA_PLANE_EN_BIT 8
`define WIN_V_HI 15
`define WIN_V_LO 8
`define WIN_H_HI 7
`define WIN_H_LO 0
`define HORIZONTAL_END_POSITION_TOP 2'h1
`define RESET_16 16'h0000

`endif

// ==== core/bitplane_fetch_pkg.sv ====
// state types of the bit-plane fetch address generator
// assumes bitplane_fetch_defines.svh is on the include path
`include "bitplane_fetch_defines.svh"
package bitplane_fetch_pkg;

  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_WAIT
  } fetch_state_t;

  typedef struct packed {
    logic [`MAX_PLANES-1:0][`PTR_W-1:0] ptr;
  } ptr_bank_t;

  typedef struct packed {
    logic addr_ph;
    logic addr_wr;
    logic [11:0] addr_idx;
    logic hreadyout;
    logic [31:0] hrdata;
    logic [15:0] win_start;
    logic [15:0] win_stop;
    logic [15:0] fetch_start;
    logic [15:0] fetch_stop;
    logic [15:0] ctl_main;
    logic [15:0] scroll;
    logic [15:0] odd_skip;
    logic [15:0] even_skip;
    logic [15:0] dma_ctl;
    logic [2:0] div_cnt;
    logic [1:0] sub_cnt;
    logic [7:0] hpos;
    logic [8:0] vpos;
    logic long_field;
    fetch_state_t fstate;
    logic [2:0] plane;
    logic slot_pending;
    logic line_fetched;
    logic eol_pending;
    logic [4:0] lat_cnt;
    logic mem_req;
    logic [`PTR_W-1:0] mem_addr;
    logic [15:0] plane_word;
    logic plane_word_valid;
    logic [2:0] plane_word_index;
    logic display_start;
    logic in_window;
    logic burst_en;
    logic hires;
    logic alternate_field_scan_select;
    logic line_end;
  } fetch_core_t;

endpackage

// ==== core/ptr_bus_if.sv ====
// link between the fetch control and the plane pointer bank
// assumes both ends run on the same sys_clk
`include "bitplane_fetch_defines.svh"
interface ptr_bus_if;
  logic wr_hi;
  logic wr_lo;
  logic [2:0] wr_plane;
  logic [15:0] wr_data;
  logic step;
  logic [2:0] step_plane;
  logic eol_add;
  logic [2:0] eol_planes;
  logic [15:0] odd_skip;
  logic [15:0] even_skip;
  logic [2:0] rd_plane;
  logic [`PTR_W-1:0] rd_ptr;

  modport ctrl (
    output wr_hi, wr_lo, wr_plane, wr_data, step, step_plane,
    output eol_add, eol_planes, odd_skip, even_skip, rd_plane,
    input rd_ptr
  );
  modport bank (
    input wr_hi, wr_lo, wr_plane, wr_data, step, step_plane,
    input eol_add, eol_planes, odd_skip, even_skip, rd_plane,
    output rd_ptr
  );
endinterface

// ==== core/plane_pointer_bank.sv ====
// per-plane word pointers: software load, step after fetch, line skip
// assumes one request source per cycle from the fetch control
`include "bitplane_fetch_defines.svh"
module plane_pointer_bank (
  input wire logic sys_clk,
  input wire logic rst_n,
  ptr_bus_if.bank pb
);
  bitplane_fetch_pkg::ptr_bank_t state;
  bitplane_fetch_pkg::ptr_bank_t next_state;

  // signed skip, low bit dropped so pointers stay on words
  function automatic logic [`PTR_W-1:0] skip_of(input logic [15:0] m);
    skip_of = {{(`PTR_W-16){m[15]}}, m[15:1], 1'b0};
  endfunction

  always_comb begin
    next_state = state;
    for (int p = 0; p < `MAX_PLANES; p++) begin
      if (pb.eol_add && 3'(p) < pb.eol_planes) begin
        if (p % 2 == 0) begin
          next_state.ptr[p] = state.ptr[p] + skip_of(pb.odd_skip); // R08 R10
        end else begin
          next_state.ptr[p] = state.ptr[p] + skip_of(pb.even_skip); // R10
        end
      end else if (pb.step && 3'(p) == pb.step_plane) begin
        next_state.ptr[p] = state.ptr[p] + `WORD_BYTES; // R07
      end
      // software load wins over a step in the same cycle
      if (pb.wr_hi && 3'(p) == pb.wr_plane) begin
        next_state.ptr[p][`PTR_W-1:16] = pb.wr_data[`PTR_W-17:0];
      end
      if (pb.wr_lo && 3'(p) == pb.wr_plane) begin
        next_state.ptr[p][15:0] = {pb.wr_data[15:1], 1'b0}; // R09
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pb.rd_ptr = state.ptr[pb.rd_plane];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_ptr_step;
    pb.step && pb.step_plane == 3'h0 && !pb.eol_add && !pb.wr_hi
      && !pb.wr_lo |=> state.ptr[0] == $past(state.ptr[0]) + `WORD_BYTES;
  endproperty
  a_ptr_step: assert property (p_ptr_step) // R07
    else $error("plane pointer did not advance by one word");

  property p_ptr_even;
    ##1 (state.ptr[0][0] | state.ptr[1][0] | state.ptr[2][0]
      | state.ptr[3][0] | state.ptr[4][0] | state.ptr[5][0]) == 1'b0;
  endproperty
  a_ptr_even: assert property (p_ptr_even) // R09
    else $error("plane pointer holds an odd byte address");

  property p_skip_split;
    pb.eol_add && pb.eol_planes >= 3'h2 && !pb.wr_hi && !pb.wr_lo
      |=> state.ptr[0] == $past(state.ptr[0]) + skip_of($past(pb.odd_skip))
      && state.ptr[1] == $past(state.ptr[1])
        + skip_of($past(pb.even_skip));
  endproperty
  a_skip_split: assert property (p_skip_split) // R08 R10
    else $error("line skip not applied per odd and even plane");
endmodule

// ==== bench/display_mem_model.sv ====
// word-wide display memory answering the fetch requests
// assumes one request at a time, held until the edge that samples mem_ack
module display_mem_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic mem_req,
  input wire logic [18:0] mem_addr,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  logic slow;
  // waits at least two cycles so a freshly stepped address has settled;
  // alternates prompt and slow answers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      wait_cnt <= 3'h0;
      slow <= 1'b0;
    end else if (mem_req && !mem_ack && wait_cnt == (slow ? 3'h4 : 3'h2)) begin
      mem_ack <= 1'b1;
      mem_rdata <= ~mem_addr[15:0];
      wait_cnt <= 3'h0;
      slow <= !slow;
    end else begin
      mem_ack <= 1'b0;
      // outside an answer the data lines invert each cycle, so the last word shows only every other cycle
      mem_rdata <= ~mem_rdata;
      if (mem_ack)
        wait_cnt <= 3'h0;
      else if (mem_req)
        wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule

// ==== bench/bitplane_fetch_address_gen_tb_top.sv ====
// self-checking bench: register access over the bus, fetch address trace
// assumes the display memory model answers every fetch request
`include "bitplane_fetch_defines.svh"
module bitplane_fetch_address_gen_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hreadyout, hresp, mem_req, mem_ack, plane_word_valid;
  logic [31:0] hrdata, rd;
  logic [18:0] mem_addr;
  logic [15:0] mem_rdata, plane_word, v;
  logic [2:0] plane_word_index;
  logic disp_start, in_win, burst, hires, alternate_field_scan_select, long_fld, line_end;
  logic [18:0] got[$];
  logic [18:0] exp_addr[8] = '{19'h0_1000, 19'h0_2000, 19'h0_1002,
    19'h0_2002, 19'h0_1014, 19'h0_2024, 19'h0_1016, 19'h0_2026};
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  int ends = 0;
  int win_cyc;
  int np = 2;

  always #12.5 sys_clk = ~sys_clk;

  bitplane_fetch_address_gen DUT (.sys_clk(sys_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .plane_word(plane_word),
    .plane_word_valid(plane_word_valid),
    .plane_word_index(plane_word_index), .display_start(disp_start),
    .in_display_window(in_win), .colour_burst_en(burst),
    .hires_mode(hires), .interlace_mode(alternate_field_scan_select), .long_field(long_fld),
    .fetch_line_end(line_end));

  display_mem_model mem (.sys_clk(sys_clk), .rst_n(rst_n),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  task cmp(input logic [31:0] got_v, input logic [31:0] exp_v);
    comparisons++;
    if (got_v !== exp_v) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask

  task ahb_access(input logic wr, input logic [11:0] idx,
                  input logic [15:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= {18'h0_0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task ahb_write(input logic [11:0] idx, input logic [15:0] d);
    ahb_access(1'b1, idx, d);
  endtask

  task test_done;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // fetch trace: address taken at the answering edge
  always @(posedge sys_clk) begin
    if (rst_n && mem_req === 1'b1 && mem_ack === 1'b1)
      got.push_back(mem_addr);
    if (plane_word_valid === 1'b1 && got.size() > 0) begin
      cmp({16'h0000, plane_word}, {16'h0000, ~got[$][15:0]});
      cmp({29'h0, plane_word_index}, 32'((got.size() - 1) % np));
    end
    if (line_end === 1'b1)
      ends++;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      test_done();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    cmp({31'h0, hreadyout}, 32'h1);
    cmp({31'h0, long_fld}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 16'h8000 : (i == 1) ? 16'h0004 : 16'h0200;
      ahb_write(`IDX_CTL_MAIN, v);
      repeat (2) @(posedge sys_clk);
      cmp({29'h0, hires, alternate_field_scan_select, burst}, {29'h0, v[15], v[2], v[9]});
    end
    ahb_access(1'b0, 12'h3FF, 16'h0000);
    cmp(rd, 32'h0000_0000);
    cmp({31'h0, hresp}, 32'h0);
    ahb_access(1'b0, `IDX_BEAM_STATUS, 16'h0000);
    cmp({31'h0, rd[24]}, 32'h1);
    // window in low-res non-interlaced units; top stop bit implied
    // 200 lines by 320 pixels
    ahb_write(`IDX_WIN_START, 16'h0081);
    ahb_write(`IDX_WIN_STOP, 16'hC8C1);
    ahb_write(`IDX_CTL_MAIN, 16'h2000);
    ahb_write(`IDX_FETCH_START, 16'h0038);
    ahb_write(`IDX_FETCH_STOP, 16'h0040);
    ahb_write(`IDX_ODD_SKIP, 16'h0010);
    ahb_write(`IDX_EVEN_SKIP, 16'h0020);
    ahb_write(12'h0E0, 16'h0000);
    ahb_write(12'h0E2, 16'h1000);
    ahb_write(12'h0E4, 16'h0000);
    ahb_write(12'h0E6, 16'h2000);
    ahb_access(1'b0, 12'h0E2, 16'h0000);
    cmp(rd, 32'h0000_0000);
    ahb_write(`IDX_DMA_CTL, 16'h0100);
    while (got.size() < 8)
      @(posedge sys_clk);
    ahb_write(`IDX_DMA_CTL, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      cmp({13'h0, got[i]}, {13'h0, exp_addr[i]});
    end
    n = got.size();
    // one whole line: 0xE4 positions of 20 clocks; window 320 pixels of 5
    win_cyc = 0;
    repeat (4560) begin
      @(posedge sys_clk);
      if (in_win === 1'b1)
        win_cyc++;
    end
    cmp(32'(got.size()), 32'(n));
    cmp(32'(win_cyc), 32'h0000_0640);
    cmp(32'(ends), 32'h0000_0002);
    // hires, one plane: slots 0x3C, 0x40 and stop plus 4 give three words
    // start well past 0x44 so the whole next line is fetched
    repeat (1000) @(posedge sys_clk);
    np = 1;
    ahb_write(`IDX_CTL_MAIN, 16'h9000);
    ahb_write(`IDX_FETCH_START, 16'h003C);
    ahb_write(12'h0E2, 16'h3000);
    ahb_write(`IDX_DMA_CTL, 16'h0100);
    while (got.size() < n + 3)
      @(posedge sys_clk);
    repeat (200) @(posedge sys_clk);
    ahb_write(`IDX_DMA_CTL, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      cmp({13'h0, got[n + i]}, {13'h0, 19'h0_3000 + 19'(2 * i)});
    end
    cmp(32'(got.size()), 32'(n + 3));
    ahb_write(`IDX_FETCH_STOP, 16'h00D0);
    ahb_access(1'b0, `IDX_FETCH_STOP, 16'h0000);
    cmp(rd, 32'h0000_00D0);
    ahb_write(`IDX_ODD_SKIP, 16'h0028);
    ahb_access(1'b0, `IDX_ODD_SKIP, 16'h0000);
    cmp(rd, 32'h0000_0028);
    test_done();
  end
endmodule
